// File: hdl/tpg_top.sv
// test pattern generator with pixel-clock launch of data and framing
`timescale 1ns/10ps
module tpg_top
    import tpg_pkg::*;
(
    input  wire logic     core_clk,
    input  wire logic     sys_rst,
    input  wire logic     pix_clk,
    input  wire tpg_pix_t pix_in,
    input  wire tpg_cfg_t cfg,
    output tpg_out_t      pix_out
);
    // ------------------------------------------------------------
    // pixel clock sampling, edge found where stages 2 and 3 agree
    // ------------------------------------------------------------
    logic [SYNC_DEPTH-1:0] pclk_sync_ff;
    logic                  pclk_seen_ff;
    logic                  agree;
    logic                  rise;

    // cleared in reset so a pin already high gives one clean rise after release
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pclk_sync_ff <= '0;
        end else begin
            pclk_sync_ff <= {pclk_sync_ff[SYNC_DEPTH-2:0], pix_clk};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pclk_seen_ff <= 1'b0;
        end else if (agree) begin
            pclk_seen_ff <= pclk_sync_ff[2];
        end
    end

    // a level counts only once two stages hold it, so a metastable first stage is ignored
    assign agree = (pclk_sync_ff[1] == pclk_sync_ff[2]);
    // limitation: each pixel clock level must last at least four core cycles, or edges
    // are missed and the launch can trail the receiver's falling edge
    assign rise  = agree && pclk_sync_ff[2] && !pclk_seen_ff;

    // ------------------------------------------------------------
    // position counters, advanced at most once per pixel clock
    // ------------------------------------------------------------
    logic [CNT_W-1:0] col_ff;
    logic [CNT_W-1:0] row_ff;
    logic [CNT_W-1:0] hbar_ff;
    logic [CNT_W-1:0] vbar_ff;
    logic             hodd_ff;
    logic             vodd_ff;
    logic [PIX_W-1:0] walk_ff;
    logic             lv_d_ff;
    logic             act;
    logic             row_end;

    // pix_in and cfg are taken only at a detected rise, after the sensor side has held
    // them for most of a pixel period, so they need no synchroniser of their own
    // dark pixels hold the column counter, vertical bar stepper and walking one, so patterns stay aligned to the active area
    assign act     = pix_in.frame_valid && pix_in.line_valid && !pix_in.dark;
    assign row_end = lv_d_ff && !pix_in.line_valid;

    // zero-width bars would never advance, treat as one
    function automatic logic bar_done(input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] width);
        bar_done = ({1'b0, cnt} + 17'h00001) >= {1'b0, width};
    endfunction

    // counters wrap silently; only their low bits ever reach the output
    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] cnt);
        step = cnt + 16'h0001;
    endfunction

    // line level at the previous pixel; its fall marks the end of a row
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lv_d_ff <= 1'b0;
        end else if (rise) begin
            lv_d_ff <= pix_in.line_valid;
        end
    end

    // ------------------------------------------------------------
    // column counter and vertical bar stepper
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            col_ff  <= CNT_ZERO;
            vbar_ff <= CNT_ZERO;
            vodd_ff <= 1'b0;
        end else if (rise) begin
            if (!pix_in.line_valid) begin
                col_ff  <= CNT_ZERO;
                vbar_ff <= CNT_ZERO;
                vodd_ff <= 1'b0;
            end else if (act) begin
                col_ff <= step(col_ff);
                if (bar_done(vbar_ff, cfg.bar_width)) begin
                    vbar_ff <= CNT_ZERO;
                    vodd_ff <= !vodd_ff;
                end else begin
                    vbar_ff <= step(vbar_ff);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // row counter and horizontal bar stepper
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            row_ff  <= CNT_ZERO;
            hbar_ff <= CNT_ZERO;
            hodd_ff <= 1'b0;
        end else if (rise) begin
            if (!pix_in.frame_valid) begin
                row_ff  <= CNT_ZERO;
                hbar_ff <= CNT_ZERO;
                hodd_ff <= 1'b0;
            end else if (row_end) begin
                row_ff <= step(row_ff);
                if (bar_done(hbar_ff, cfg.bar_width)) begin
                    hbar_ff <= CNT_ZERO;
                    hodd_ff <= !hodd_ff;
                end else begin
                    hbar_ff <= step(hbar_ff);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // walking one restarts at bit zero outside lines
    // ------------------------------------------------------------
    // a rotation, not a shift, so the bit returns to zero after the top bit
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            walk_ff <= WALK_FIRST;
        end else if (rise) begin
            if (!pix_in.line_valid) begin
                walk_ff <= WALK_FIRST;
            end else if (act) begin
                walk_ff <= {walk_ff[PIX_W-2:0], walk_ff[PIX_W-1]};
            end
        end
    end

    // ------------------------------------------------------------
    // pattern select
    // ------------------------------------------------------------
    logic [PIX_W-1:0] pat;
    logic [PIX_W-1:0] dark_lvl;
    logic [PIX_W-1:0] nxt_data;
    logic [CNT_W-1:0] diag;

    // full-width sum, cut to the pixel width at the mux
    assign diag = col_ff + row_ff;

    always_comb begin
        unique case (cfg.mode)
            MODE_HGRAD: pat = col_ff[PIX_W-1:0];
            MODE_VGRAD: pat = row_ff[PIX_W-1:0];
            MODE_DGRAD: pat = diag[PIX_W-1:0];
            MODE_WALK:  pat = walk_ff;
            MODE_HBARS: pat = hodd_ff ? cfg.level_blue : cfg.level_green;
            MODE_VBARS: pat = vodd_ff ? cfg.level_blue : cfg.level_green;
            // unsupported codes pass sensor data through
            default:    pat = pix_in.data;
        endcase
    end

    // ------------------------------------------------------------
    // dark pixel level by color
    // ------------------------------------------------------------
    always_comb begin
        unique case (pix_in.color)
            COLOR_RED:  dark_lvl = cfg.level_red;
            COLOR_BLUE: dark_lvl = cfg.level_blue;
            default:    dark_lvl = cfg.level_green;
        endcase
    end

    // ------------------------------------------------------------
    // output word and launch
    // ------------------------------------------------------------
    // enable off leaves sensor data untouched; dark pixels win over any mode
    always_comb begin
        if (!cfg.enable) begin
            nxt_data = pix_in.data;
        end else if (pix_in.dark) begin
            nxt_data = dark_lvl;
        end else begin
            nxt_data = pat;
        end
    end

    // launched only at pixel clock rise so the receiver's falling edge sees it stable
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pix_out <= '{frame_valid: 1'b0, line_valid: 1'b0, data: PIX_ZERO};
        end else if (rise) begin
            pix_out.frame_valid <= pix_in.frame_valid;
            pix_out.line_valid  <= pix_in.line_valid;
            pix_out.data        <= nxt_data;
        end
    end
endmodule

// File: hdl/tpg_pkg.sv
// package for the test pattern generator: modes, carriers, widths
package tpg_pkg;
    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int          PIX_W       = 12;
    localparam int          CNT_W       = 16;
    localparam int          MODE_W      = 4;
    localparam int          SYNC_DEPTH  = 3;
    localparam logic [3:0]  MODE_HGRAD  = 4'h1;
    localparam logic [3:0]  MODE_VGRAD  = 4'h2;
    localparam logic [3:0]  MODE_DGRAD  = 4'h3;
    localparam logic [3:0]  MODE_WALK   = 4'h5;
    localparam logic [3:0]  MODE_HBARS  = 4'h6;
    localparam logic [3:0]  MODE_VBARS  = 4'h7;
    localparam logic [11:0] PIX_ZERO    = 12'h000;
    localparam logic [11:0] WALK_FIRST  = 12'h001;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;

    // sensor-side pixel word with its qualifiers
    typedef struct packed {
        logic        frame_valid;
        logic        line_valid;
        logic        dark;
        logic [1:0]  color;
        logic [11:0] data;
    } tpg_pix_t;

    // bayer color codes on the color field
    localparam logic [1:0] COLOR_GREEN = 2'h0;
    localparam logic [1:0] COLOR_RED   = 2'h1;
    localparam logic [1:0] COLOR_BLUE  = 2'h2;

    // software configuration
    typedef struct packed {
        logic        enable;
        logic [3:0]  mode;
        logic [11:0] level_green;
        logic [11:0] level_red;
        logic [11:0] level_blue;
        logic [15:0] bar_width;
    } tpg_cfg_t;

    // outgoing parallel word
    typedef struct packed {
        logic        frame_valid;
        logic        line_valid;
        logic [11:0] data;
    } tpg_out_t;
endpackage

// File: tb/tpg_rx_model.sv
// receiver model: captures the pixel word on the falling pixel clock edge
`timescale 1ns/10ps
module tpg_rx_model
    import tpg_pkg::*;
(
    input  wire logic     pix_clk,
    input  wire tpg_out_t pix_out,
    output tpg_out_t      cap
);
    always @(negedge pix_clk) cap <= pix_out;
endmodule

// File: tb/tpg_assertions.sv
// port checker of the test pattern generator
`timescale 1ns/10ps
module tpg_assertions
    import tpg_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     sys_rst,
    input wire logic     pix_clk,
    input wire tpg_pix_t pix_in,
    input wire tpg_cfg_t cfg,
    input wire tpg_out_t pix_out
);
    // --------
    // helpers
    // --------
    logic clk_ff, lv_ff, rise, act, go;
    assign rise = pix_clk & ~clk_ff;
    assign act  = pix_in.frame_valid & pix_in.line_valid & ~pix_in.dark;
    assign go   = rise & cfg.enable & act & ~lv_ff;
    always_ff @(posedge core_clk) clk_ff <= ~sys_rst & pix_clk;
    // line level seen at the previous pixel marks a row start
    always_ff @(posedge core_clk) lv_ff <= ~sys_rst & (rise ? pix_in.line_valid : lv_ff);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_quiet_low: assert property (!pix_clk |-> $stable(pix_out))
        else $error("output moved");
    a_frame_copy: assert property (rise |-> ##6
        pix_out.frame_valid == $past(pix_in.frame_valid, 6)) else $error("frame_valid");
    a_line_copy: assert property (rise |-> ##6
        pix_out.line_valid == $past(pix_in.line_valid, 6)) else $error("line_valid");
    a_pass_off: assert property (rise && !cfg.enable |-> ##6
        pix_out.data == $past(pix_in.data, 6)) else $error("pass data");
    a_other_mode: assert property (rise && cfg.enable && act && cfg.mode inside {0, 4}
        |-> ##6 pix_out.data == $past(pix_in.data, 6)) else $error("other mode");
    a_dark_red: assert property (rise && cfg.enable && pix_in.dark && pix_in.line_valid
        && pix_in.frame_valid && pix_in.color == COLOR_RED |-> ##6 pix_out.data == cfg.level_red)
        else $error("dark level");
    a_walk_first: assert property (go && cfg.mode == MODE_WALK |-> ##6
        pix_out.data == WALK_FIRST) else $error("walk start");
    a_grad_zero: assert property (go && cfg.mode == MODE_HGRAD |-> ##6
        pix_out.data == PIX_ZERO) else $error("gradient start");
endmodule
bind tpg_top tpg_assertions i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .pix_clk(pix_clk),
    .pix_in(pix_in), .cfg(cfg), .pix_out(pix_out));

// File: tb/test_tpg_top.sv
// self-checking bench of the test pattern generator
`timescale 1ns/10ps
module test_tpg_top
    import tpg_pkg::*;
;
    logic        core_clk, sys_rst, pix_clk, plv, no_dark;
    tpg_pix_t    pix_in;
    tpg_cfg_t    cfg;
    tpg_out_t    pix_out, cap;
    logic [15:0] col, row;
    logic [11:0] walk;
    int          seed = 32'hf9f9be0d, bad_count = 0, comparisons = 0, cycles = 0;
    tpg_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .pix_clk(pix_clk), .pix_in(pix_in),
                   .cfg(cfg), .pix_out(pix_out));
    tpg_rx_model i_rx (.pix_clk(pix_clk), .pix_out(pix_out), .cap(cap));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // odd offset keeps the pixel clock out of phase with the core clock
    initial begin
        pix_clk = 1'b0;
        #1.3;
        forever #62.5 pix_clk = ~pix_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // --------
    // checks
    // --------
    task automatic check_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_word(input string n, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [11:0] exp_data(tpg_pix_t p);
        logic [15:0] bw;
        bw = (cfg.bar_width == 16'h0) ? 16'h1 : cfg.bar_width;
        if (!cfg.enable) return p.data;
        if (p.dark) return p.color == COLOR_RED ? cfg.level_red :
                           p.color == COLOR_BLUE ? cfg.level_blue : cfg.level_green;
        case (cfg.mode)
            MODE_HGRAD: return col[11:0];
            MODE_VGRAD: return row[11:0];
            MODE_DGRAD: return 12'(col + row);
            MODE_WALK:  return walk;
            MODE_HBARS: return ((row / bw) % 2) ? cfg.level_blue : cfg.level_green;
            MODE_VBARS: return ((col / bw) % 2) ? cfg.level_blue : cfg.level_green;
            default:    return p.data;
        endcase
    endfunction
    // one pixel: launch after a fall, judge the capture at the next fall
    task automatic pix(input logic fv, input logic lv);
        tpg_pix_t    p;
        logic [11:0] e;
        @(posedge core_clk);
        p = '{fv, lv, !no_dark && ($random(seed) & 7) == 0,
              2'($random(seed)), 12'($random(seed))};
        pix_in <= p;
        e = exp_data(p);
        if (!lv) begin
            col = 16'h0;
            walk = WALK_FIRST;
        end else if (fv && !p.dark) begin
            col++;
            walk = {walk[10:0], walk[11]};
        end
        row = !fv ? 16'h0 : row + 16'(plv && !lv);
        plv = lv;
        @(negedge pix_clk);
        #1;
        check_bit("frame_valid", fv, cap.frame_valid);
        check_bit("line_valid", lv, cap.line_valid);
        if (!cfg.enable || (fv && lv))
            check_word("data", e, cap.data);
    endtask
    // rows of 14 pixels; the first row has no dark pixels, so the walking bit surely wraps
    task automatic frame();
        repeat (2) pix(1'b0, 1'b0);
        for (int r = 0; r < 3; r++) begin
            no_dark = (r == 0);
            repeat (14) pix(1'b1, 1'b1);
            repeat (2) pix(1'b1, 1'b0);
        end
        no_dark = 1'b0;
    endtask
    // mid-run reset between frames: outputs clear at once, the next frame starts clean
    task automatic pulse_reset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check_bit("reset frame_valid", 1'b0, pix_out.frame_valid);
        check_bit("reset line_valid", 1'b0, pix_out.line_valid);
        check_word("reset data", PIX_ZERO, pix_out.data);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        pix_in = '0;
        cfg = '0;
        {col, row, plv, no_dark} = '0;
        walk = WALK_FIRST;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(negedge pix_clk);
        // codes 0 to 8 enabled, then pattern off
        for (int m = 0; m < 10; m++) begin
            if (m == 5)
                pulse_reset();
            @(posedge core_clk);
            cfg <= '{m < 9, 4'(m), 12'($random(seed)), 12'($random(seed)), 12'($random(seed)),
                     m == 7 ? 16'h0 : 16'($random(seed) & 3)};
            frame();
            $display("test mode %0d done", m);
        end
        report_and_stop();
    end
endmodule
